// ==== pkg/oad_pkg.sv ====
`default_nettype none
package oad_pkg;
  localparam int WORD_W = 16;
  localparam int REG_COUNT = 8;
  localparam int BYTE_BIT = 15;
  localparam int OPC_HI = 14;
  localparam int OPC_LO = 6;
  localparam int SUM_HI = 15;
  localparam int SUM_LO = 12;
  localparam int SRC_HI = 11;
  localparam int SRC_LO = 6;
  localparam int DST_HI = 5;
  localparam int DST_LO = 0;
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int DEF_BIT = 3;
  localparam int REG_HI = 2;
  localparam int REG_LO = 0;
  localparam logic [8:0] OPC_ZERO = 9'h028;
  localparam logic [8:0] OPC_COMPL = 9'h029;
  localparam logic [8:0] OPC_ADD1 = 9'h02a;
  localparam logic [3:0] OPC_SUM = 4'h6;
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_INC = 2'h1;
  localparam logic [1:0] MODE_DEC = 2'h2;
  localparam logic [1:0] MODE_IDX = 2'h3;
  localparam logic [2:0] REG_SP = 3'h6;
  localparam logic [2:0] REG_PC = 3'h7;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_RREG = 11'h002,
    ST_RDAT = 11'h004,
    ST_PCRD = 11'h008,
    ST_PCDAT = 11'h010,
    ST_IDXF = 11'h020,
    ST_DEFR = 11'h040,
    ST_OPRD = 11'h080,
    ST_UPD = 11'h100,
    ST_EXEC = 11'h200,
    ST_WRT = 11'h400
  } oad_state_type;

  typedef enum logic [3:0] {
    OP_ZERO = 4'h1,
    OP_COMPL = 4'h2,
    OP_ADD1 = 4'h4,
    OP_SUM = 4'h8
  } oad_op_type;

  typedef struct packed {
    oad_state_type st;
    oad_op_type op;
    logic phase;
    logic byte_op;
    logic [5:0] src_spec;
    logic [5:0] dst_spec;
    logic [15:0] addr;
    logic [15:0] base;
    logic [15:0] pc;
    logic [15:0] upd_val;
    logic upd_pend;
    logic [15:0] src_val;
    logic [15:0] dst_val;
    logic dst_is_reg;
    logic busy;
    logic done;
    logic illegal;
    logic [15:0] result_value;
    logic result_at_reg;
    logic [2:0] result_reg;
    logic [15:0] result_addr;
    logic mem_req;
    logic mem_we;
    logic mem_byte;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
  } oad_ctx_type;
endpackage : oad_pkg
`default_nettype wire

// ==== hdl/oad_regfile.sv ====
`timescale 1ns/1ps
`default_nettype none
// Eight general registers, one registered read port, one write port
module oad_regfile #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_reg[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem_reg[raddr];
    end
  end
endmodule : oad_regfile
`default_nettype wire

// ==== hdl/oad_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1 - Bits 15..6 of a one-operand word select the operation.
// RQ2 - Bits 5..0 of a one-operand word form the destination specifier.
// RQ3 - Specifier bits 2..0 pick one of eight general registers.
// RQ4 - Specifier bits 5..4 pick register use; bit 3 picks deferred access.
// RQ5 - Two-operand words carry separate source and destination specifiers.
// RQ6 - Addition writes the sum to destination and leaves source unchanged.
// RQ7 - Patterns 0050 and 1050 write zero to destination word or byte.
// RQ8 - Patterns 0052 and 1052 add one to destination word or byte.
// RQ9 - Patterns 0051 and 1051 invert every bit of destination word or byte.
// RQ10 - Pattern 06 adds source operand into destination operand.
// RQ11 - Mode 000 uses the register itself, no memory access.
// RQ12 - Mode 010 uses register as address, steps it after the access.
// RQ13 - Post step is one for bytes, two for words, SP and PC.
// RQ14 - Mode 100 decrements the register first, then uses it as address.
// RQ15 - Pre decrement is two for words and one for bytes.
// RQ16 - Mode 110 adds the following index word to register, modifying neither.
// RQ17 - Byte operations on a register touch only bits 7..0.
// RQ18 - Deferred mode 011 reads an address word, then steps register by two.
// RQ19 - Every word fetched through the PC advances the PC by two.
// RQ20 - Bit 15 of the one-operand opcodes selects a byte operation.
// RQ21 - Two-operand source is bits 11..6, destination is bits 5..0.
module oad_decoder
  import oad_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic load_valid,
  input wire logic [2:0] load_index,
  input wire logic [15:0] load_data,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [15:0] result_value,
  output logic result_at_reg,
  output logic [2:0] result_reg,
  output logic [15:0] result_addr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  oad_ctx_type cs_reg;
  oad_ctx_type cs_next;
  logic [2:0] rf_raddr;
  logic [15:0] rf_rdata;
  logic rf_we;
  logic [2:0] rf_waddr;
  logic [15:0] rf_wdata;
  logic [5:0] cur_spec;
  logic [2:0] cur_reg;
  logic [1:0] cur_mode;
  logic cur_def;
  logic [15:0] step_inc;
  logic [15:0] step_dec;
  logic [15:0] op_res;
  logic [8:0] opc9;
  logic is_sum;
  logic skip_read;

  ////////////////////////////////////////////////////////////////////////////
  oad_regfile #(
    .WIDTH(WORD_W),
    .DEPTH(REG_COUNT),
    .AW(3)
  ) u_regs (
    .clk(clk),
    .arst_n(arst_n),
    .raddr(rf_raddr),
    .rdata(rf_rdata),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign opc9 = instr_word[OPC_HI:OPC_LO]; // [RQ1]
  assign is_sum = (instr_word[SUM_HI:SUM_LO] == OPC_SUM); // [RQ10]
  assign cur_spec = cs_reg.phase ? cs_reg.dst_spec : cs_reg.src_spec; // [RQ5]
  assign cur_reg = cur_spec[REG_HI:REG_LO]; // [RQ3]
  assign cur_mode = cur_spec[MODE_HI:MODE_LO]; // [RQ4]
  assign cur_def = cur_spec[DEF_BIT]; // [RQ4]
  // Deferred forms always step by a whole word
  assign step_inc = (cs_reg.byte_op && !cur_def && (cur_reg < REG_SP)) ? STEP_ONE : STEP_TWO; // [RQ13] [RQ18]
  assign step_dec = (cs_reg.byte_op && !cur_def) ? STEP_ONE : STEP_TWO; // [RQ15]
  assign skip_read = cs_reg.phase && (cs_reg.op == OP_ZERO);

  always_comb
  begin
    unique case (cs_reg.op)
      OP_ZERO: op_res = WORD_RST; // [RQ7]
      OP_COMPL: op_res = ~cs_reg.dst_val; // [RQ9]
      OP_ADD1: op_res = cs_reg.dst_val + STEP_ONE; // [RQ8]
      OP_SUM: op_res = cs_reg.src_val + cs_reg.dst_val; // [RQ10] [RQ6]
      default: op_res = WORD_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic go_acc;
    logic go_read;
    logic [15:0] acc_addr;
    logic [15:0] rd_addr;
    logic [15:0] wr_val;
    go_acc = 1'b0;
    go_read = 1'b0;
    acc_addr = WORD_RST;
    rd_addr = WORD_RST;
    wr_val = WORD_RST;
    cs_next = cs_reg;
    cs_next.done = 1'b0;
    cs_next.illegal = 1'b0;
    rf_raddr = cur_reg;
    rf_we = 1'b0;
    rf_waddr = cur_reg;
    rf_wdata = WORD_RST;
    unique case (cs_reg.st)
      ST_IDLE:
      begin
        if (load_valid)
        begin
          rf_we = 1'b1;
          rf_waddr = load_index;
          rf_wdata = load_data;
        end
        if (instr_valid)
        begin
          cs_next.src_spec = instr_word[SRC_HI:SRC_LO]; // [RQ21]
          cs_next.dst_spec = instr_word[DST_HI:DST_LO]; // [RQ2] [RQ21]
          cs_next.byte_op = instr_word[BYTE_BIT] && !is_sum; // [RQ20]
          cs_next.phase = !is_sum; // [RQ5]
          cs_next.dst_is_reg = 1'b0;
          cs_next.st = ST_RREG;
          cs_next.busy = 1'b1;
          if (is_sum)
          begin
            cs_next.op = OP_SUM;
          end
          else if (opc9 == OPC_ZERO)
          begin
            cs_next.op = OP_ZERO;
          end
          else if (opc9 == OPC_COMPL)
          begin
            cs_next.op = OP_COMPL;
          end
          else if (opc9 == OPC_ADD1)
          begin
            cs_next.op = OP_ADD1;
          end
          else
          begin
            cs_next.st = ST_IDLE;
            cs_next.busy = 1'b0;
            cs_next.illegal = 1'b1;
          end
        end
      end
      ST_RREG:
      begin
        cs_next.upd_pend = 1'b0;
        cs_next.st = ST_RDAT;
      end
      ST_RDAT:
      begin
        unique case (cur_mode)
          MODE_REG:
          begin
            if (cur_def)
            begin
              go_read = 1'b1;
              rd_addr = rf_rdata;
            end
            else
            begin
              if (cs_reg.phase) // [RQ11]
              begin
                cs_next.dst_val = rf_rdata;
                cs_next.dst_is_reg = 1'b1;
              end
              else
              begin
                cs_next.src_val = rf_rdata;
              end
              cs_next.st = ST_UPD;
            end
          end
          MODE_INC:
          begin
            // Register moves in ST_UPD, after any operand read but before the result write
            cs_next.upd_val = rf_rdata + step_inc; // [RQ12] [RQ13]
            cs_next.upd_pend = 1'b1;
            go_acc = 1'b1;
            acc_addr = rf_rdata;
          end
          MODE_DEC:
          begin
            rf_we = 1'b1; // [RQ14]
            rf_wdata = rf_rdata - step_dec; // [RQ15]
            go_acc = 1'b1;
            acc_addr = rf_rdata - step_dec;
          end
          MODE_IDX:
          begin
            cs_next.base = rf_rdata;
            cs_next.st = ST_PCRD;
          end
          default:
          begin
            cs_next.st = ST_IDLE;
          end
        endcase
      end
      ST_PCRD:
      begin
        rf_raddr = REG_PC;
        cs_next.st = ST_PCDAT;
      end
      ST_PCDAT:
      begin
        cs_next.pc = rf_rdata;
        rf_we = 1'b1;
        rf_waddr = REG_PC;
        rf_wdata = rf_rdata + STEP_TWO; // [RQ19]
        cs_next.mem_req = 1'b1;
        cs_next.mem_we = 1'b0;
        cs_next.mem_byte = 1'b0;
        cs_next.mem_addr = rf_rdata;
        cs_next.st = ST_IDXF;
      end
      ST_IDXF:
      begin
        if (mem_ack)
        begin
          cs_next.mem_req = 1'b0;
          go_acc = 1'b1;
          // PC as base means the stepped PC; no register is rewritten
          acc_addr = mem_rdata + ((cur_reg == REG_PC) ? (cs_reg.pc + STEP_TWO) : cs_reg.base); // [RQ16]
        end
      end
      ST_DEFR:
      begin
        if (mem_ack)
        begin
          cs_next.mem_req = 1'b0;
          go_read = 1'b1;
          rd_addr = mem_rdata; // [RQ18]
        end
      end
      ST_OPRD:
      begin
        if (mem_ack)
        begin
          cs_next.mem_req = 1'b0;
          wr_val = cs_reg.byte_op ? {BYTE_ZERO, mem_rdata[7:0]} : mem_rdata;
          if (cs_reg.phase)
          begin
            cs_next.dst_val = wr_val;
          end
          else
          begin
            cs_next.src_val = wr_val;
          end
          cs_next.st = ST_UPD;
        end
      end
      ST_UPD:
      begin
        if (cs_reg.upd_pend)
        begin
          rf_we = 1'b1; // [RQ12]
          rf_wdata = cs_reg.upd_val;
        end
        if (cs_reg.phase)
        begin
          cs_next.st = ST_EXEC;
        end
        else
        begin
          cs_next.phase = 1'b1;
          cs_next.st = ST_RREG;
        end
      end
      ST_EXEC:
      begin
        cs_next.result_at_reg = cs_reg.dst_is_reg;
        cs_next.result_reg = cur_reg;
        cs_next.result_addr = cs_reg.addr;
        if (cs_reg.dst_is_reg)
        begin
          wr_val = cs_reg.byte_op ? {cs_reg.dst_val[15:8], op_res[7:0]} : op_res; // [RQ17]
          rf_we = 1'b1;
          rf_wdata = wr_val;
          cs_next.result_value = wr_val;
          cs_next.st = ST_IDLE;
          cs_next.busy = 1'b0;
          cs_next.done = 1'b1;
        end
        else
        begin
          wr_val = cs_reg.byte_op ? {BYTE_ZERO, op_res[7:0]} : op_res;
          cs_next.result_value = wr_val;
          cs_next.mem_req = 1'b1;
          cs_next.mem_we = 1'b1;
          cs_next.mem_byte = cs_reg.byte_op;
          cs_next.mem_addr = cs_reg.addr;
          cs_next.mem_wdata = wr_val;
          cs_next.st = ST_WRT;
        end
      end
      ST_WRT:
      begin
        if (mem_ack)
        begin
          cs_next.mem_req = 1'b0;
          cs_next.mem_we = 1'b0;
          cs_next.st = ST_IDLE;
          cs_next.busy = 1'b0;
          cs_next.done = 1'b1;
        end
      end
      default:
      begin
        cs_next.st = ST_IDLE;
      end
    endcase
    if (go_acc)
    begin
      cs_next.addr = acc_addr;
      if (cur_def)
      begin
        cs_next.st = ST_DEFR;
        cs_next.mem_req = 1'b1;
        cs_next.mem_we = 1'b0;
        cs_next.mem_byte = 1'b0;
        cs_next.mem_addr = acc_addr;
      end
      else
      begin
        go_read = 1'b1;
        rd_addr = acc_addr;
      end
    end
    if (go_read)
    begin
      cs_next.addr = rd_addr;
      if (skip_read)
      begin
        cs_next.st = ST_UPD;
      end
      else
      begin
        cs_next.st = ST_OPRD;
        cs_next.mem_req = 1'b1;
        cs_next.mem_we = 1'b0;
        cs_next.mem_byte = cs_reg.byte_op;
        cs_next.mem_addr = rd_addr;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_reg <= '0;
      cs_reg.st <= ST_IDLE;
      cs_reg.op <= OP_ZERO;
    end
    else
    begin
      cs_reg <= cs_next;
    end
  end

  assign busy = cs_reg.busy;
  assign done = cs_reg.done;
  assign illegal = cs_reg.illegal;
  assign result_value = cs_reg.result_value;
  assign result_at_reg = cs_reg.result_at_reg;
  assign result_reg = cs_reg.result_reg;
  assign result_addr = cs_reg.result_addr;
  assign mem_req = cs_reg.mem_req;
  assign mem_we = cs_reg.mem_we;
  assign mem_byte = cs_reg.mem_byte;
  assign mem_addr = cs_reg.mem_addr;
  assign mem_wdata = cs_reg.mem_wdata;

  ////////////////////////////////////////////////////////////////////////////
  a_zero_result: assert property (@(posedge clk) disable iff (!arst_n) // [RQ7]
    (cs_reg.st == ST_EXEC && cs_reg.op == OP_ZERO && !cs_reg.dst_is_reg) |=> (result_value == WORD_RST))
    else $error("zero op result not zero");
  a_compl_result: assert property (@(posedge clk) disable iff (!arst_n) // [RQ9]
    (cs_reg.st == ST_EXEC && cs_reg.op == OP_COMPL) |=> (result_value[7:0] == ~$past(cs_reg.dst_val[7:0])))
    else $error("invert result wrong");
  a_add_one: assert property (@(posedge clk) disable iff (!arst_n) // [RQ8]
    (cs_reg.st == ST_EXEC && cs_reg.op == OP_ADD1) |=> (result_value[7:0] == $past(cs_reg.dst_val[7:0]) + 8'h01))
    else $error("add one result wrong");
  a_sum_result: assert property (@(posedge clk) disable iff (!arst_n) // [RQ10]
    (cs_reg.st == ST_EXEC && cs_reg.op == OP_SUM) |=> (result_value == $past(cs_reg.src_val + cs_reg.dst_val)))
    else $error("sum result wrong");
  a_byte_merge: assert property (@(posedge clk) disable iff (!arst_n) // [RQ17]
    (cs_reg.st == ST_EXEC && cs_reg.dst_is_reg && cs_reg.byte_op) |-> (rf_we && rf_wdata[15:8] == cs_reg.dst_val[15:8]))
    else $error("byte op touched upper register bits");
  a_pc_step: assert property (@(posedge clk) disable iff (!arst_n) // [RQ19]
    (cs_reg.st == ST_PCDAT) |-> (rf_we && rf_waddr == REG_PC && rf_wdata == rf_rdata + STEP_TWO))
    else $error("pc not stepped by two on fetch");
  a_reg_nomem: assert property (@(posedge clk) disable iff (!arst_n) // [RQ11]
    (cs_reg.st == ST_RDAT && cur_mode == MODE_REG && !cur_def) |=> (!mem_req && cs_reg.st == ST_UPD))
    else $error("register mode touched memory");
  a_dec_first: assert property (@(posedge clk) disable iff (!arst_n) // [RQ14]
    (cs_reg.st == ST_RDAT && cur_mode == MODE_DEC && !cur_def) |=> (cs_reg.addr == $past(rf_rdata - step_dec)))
    else $error("decrement not applied before access");
  a_inc_after: assert property (@(posedge clk) disable iff (!arst_n) // [RQ12]
    (cs_reg.st == ST_RDAT && cur_mode == MODE_INC && !cur_def) |-> (!rf_we ##1 cs_reg.addr == $past(rf_rdata)))
    else $error("increment applied before access");
  a_bad_opcode: assert property (@(posedge clk) disable iff (!arst_n) // [RQ1]
    (cs_reg.st == ST_IDLE && instr_valid && !is_sum && opc9 != OPC_ZERO && opc9 != OPC_COMPL
     && opc9 != OPC_ADD1) |=> (illegal && !busy))
    else $error("unknown opcode not flagged");
endmodule : oad_decoder
`default_nettype wire

// ==== tb/operand_address_mode_decoder_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module operand_address_mode_decoder_bench
  import oad_pkg::*;
;
  typedef struct packed {
    logic [15:0] iw;
    logic at;
    logic [2:0] rg;
    logic [15:0] ad;
    logic [15:0] rv;
  } oad_case_type;
  typedef struct packed {
    logic [15:0] iw;
    logic [2:0] rg;
    logic [15:0] ev;
  } oad_step_type;
  localparam logic [15:0] REG_INIT [8] = '{16'h0201, 16'hffff, 16'h0401, 16'h0100,
    16'h0500, 16'h12ff, 16'h0200, 16'h1000};
  logic clk, arst_n, instr_valid, load_valid, mem_ack;
  logic [15:0] instr_word, load_data, mem_rdata;
  logic [2:0] load_index;
  logic busy, done, illegal, result_at_reg, mem_req, mem_we, mem_byte;
  logic [15:0] result_value, result_addr, mem_addr, mem_wdata;
  logic [2:0] result_reg;
  logic [7:0] nb;
  logic [15:0] ew;
  logic [7:0] mem_b [0:65535];
  int n_mismatch, check_count, mem_wait, wcnt;
  oad_case_type rows [20] = '{
    '{16'h0a83, 1'b1, 3'h3, 16'h0000, 16'h0101},
    '{16'h0a01, 1'b1, 3'h1, 16'h0000, 16'h0000},
    '{16'h0a42, 1'b1, 3'h2, 16'h0000, 16'hfbfe},
    '{16'h8a05, 1'b1, 3'h5, 16'h0000, 16'h1200},
    '{16'h8a44, 1'b1, 3'h4, 16'h0000, 16'h05ff},
    '{16'h8a85, 1'b1, 3'h5, 16'h0000, 16'h1200},
    '{16'h0a93, 1'b0, 3'h0, 16'h0100, 16'h8000},
    '{16'h8aa0, 1'b0, 3'h0, 16'h0200, 16'h0041},
    '{16'h0aa6, 1'b0, 3'h0, 16'h01fe, 16'h0011},
    '{16'h8a52, 1'b0, 3'h0, 16'h0401, 16'h00f0},
    '{16'h0a34, 1'b0, 3'h0, 16'h0700, 16'h0000},
    '{16'h60c4, 1'b1, 3'h4, 16'h0000, 16'h0600},
    '{16'h64c5, 1'b1, 3'h5, 16'h0000, 16'h92fe},
    '{16'h6981, 1'b1, 3'h1, 16'h0000, 16'h000f},
    '{16'h8a15, 1'b0, 3'h0, 16'h12ff, 16'h0000},
    '{16'h0a9e, 1'b0, 3'h0, 16'h0040, 16'h1234},
    '{16'h60d6, 1'b0, 3'h0, 16'h0200, 16'h0140},
    '{16'h0a8b, 1'b0, 3'h0, 16'h0100, 16'h8000},
    '{16'h8a6e, 1'b0, 3'h0, 16'h0010, 16'h00ff},
    '{16'h0a37, 1'b0, 3'h0, 16'h1202, 16'h0000}
  };
  oad_step_type steps [12] = '{
    '{16'h8a13, 3'h3, 16'h0101}, '{16'h0a13, 3'h3, 16'h0102},
    '{16'h8a16, 3'h6, 16'h0202}, '{16'h8a17, 3'h7, 16'h1002},
    '{16'h8aa2, 3'h2, 16'h0400}, '{16'h0aa6, 3'h6, 16'h01fe},
    '{16'h8a9e, 3'h6, 16'h0202}, '{16'h0a34, 3'h4, 16'h0500},
    '{16'h0a34, 3'h7, 16'h1002}, '{16'h60c4, 3'h3, 16'h0100},
    '{16'h8a6e, 3'h6, 16'h01fe}, '{16'h0a37, 3'h7, 16'h1002}
  };
  logic [15:0] bad_ops [4] = '{16'h0ac0, 16'h0000, 16'h7000, 16'he000};

  oad_decoder i_dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .load_valid(load_valid), .load_index(load_index),
    .load_data(load_data), .busy(busy), .done(done), .illegal(illegal),
    .result_value(result_value), .result_at_reg(result_at_reg), .result_reg(result_reg),
    .result_addr(result_addr), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Memory responder; unused byte lanes and idle data carry changing garbage
  always @(posedge clk)
  begin
    if (mem_req && !mem_ack && wcnt >= mem_wait)
    begin
      mem_ack <= 1'b1;
      if (mem_we)
      begin
        mem_b[mem_addr] <= mem_wdata[7:0];
        if (!mem_byte)
          mem_b[mem_addr + 16'h0001] <= mem_wdata[15:8];
      end
      else if (mem_byte)
        mem_rdata <= {~mem_b[mem_addr], mem_b[mem_addr]};
      else
        mem_rdata <= {mem_b[mem_addr + 16'h0001], mem_b[mem_addr]};
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    wcnt <= (mem_req && !mem_ack) ? wcnt + 1 : 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic mem_word(input logic [15:0] a, input logic [15:0] v);
    mem_b[a] = v[7:0];
    mem_b[a + 16'h0001] = v[15:8];
  endtask : mem_word

  task automatic load_reg(input logic [2:0] idx, input logic [15:0] v);
    @(posedge clk);
    load_valid <= 1'b1;
    load_index <= idx;
    load_data <= v;
    @(posedge clk);
    load_valid <= 1'b0;
  endtask : load_reg

  task automatic init_state();
    for (int i = 0; i < 8; i++)
      load_reg(i[2:0], REG_INIT[i]);
    mem_word(16'h0100, 16'h7fff);
    mem_word(16'h0200, 16'h0040);
    mem_word(16'h01fe, 16'h0010);
    mem_word(16'h0400, 16'h0f00);
    mem_word(16'h1000, 16'h0200);
    mem_word(16'h0040, 16'h1233);
    // Non-zero neighbour so a byte store that spills is seen
    mem_word(16'h1300, 16'h00aa);
  endtask : init_state

  // Returns in the cycle that shows done or illegal
  task automatic wait_end();
    int k;
    k = 0;
    #1;
    while (done !== 1'b1 && illegal !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 300)
    begin
      n_mismatch++;
      $display("BAD completion expected pulse seen none");
      summarize();
    end
  endtask : wait_end

  task automatic issue(input logic [15:0] iw);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= iw;
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask : issue

  task automatic run_instr(input logic [15:0] iw);
    issue(iw);
    wait_end();
  endtask : run_instr

  // Copies a register into R0 with an add so its value shows at the result
  task automatic peek(input logic [2:0] n, input logic [15:0] exp);
    load_reg(3'h0, 16'h0000);
    run_instr(16'h6000 | {7'h00, n, 6'h00});
    check("peeked register", result_value, exp);
  endtask : peek

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    {n_mismatch, check_count, mem_wait, wcnt} = '0;
    {arst_n, instr_valid, load_valid, mem_ack} = 4'h0;
    {instr_word, load_data, mem_rdata} = '0;
    load_index = 3'h0;
    for (int a = 0; a < 65536; a++)
      mem_b[a] = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    check("busy in reset", {15'h0000, busy}, 16'h0000);
    check("mem_req in reset", {15'h0000, mem_req}, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    $display("reset test done");
    foreach (rows[i])
    begin
      init_state();
      nb = mem_b[rows[i].ad + 16'h0001];
      ew = {(rows[i].iw[15] ? nb : rows[i].rv[15:8]), rows[i].rv[7:0]};
      run_instr(rows[i].iw);
      check("result_at_reg", {15'h0000, result_at_reg}, {15'h0000, rows[i].at});
      if (rows[i].at)
        check("result_reg", {13'h0000, result_reg}, {13'h0000, rows[i].rg});
      else
      begin
        check("result_addr", result_addr, rows[i].ad);
        check("memory word", {mem_b[rows[i].ad + 16'h0001], mem_b[rows[i].ad]}, ew);
      end
      check("result_value", result_value, rows[i].rv);
      $display("row %0d done", i);
    end
    foreach (steps[i])
    begin
      init_state();
      run_instr(steps[i].iw);
      peek(steps[i].rg, steps[i].ev);
      $display("step %0d done", i);
    end
    foreach (bad_ops[i])
    begin
      run_instr(bad_ops[i]);
      check("illegal", {15'h0000, illegal}, 16'h0001);
      check("busy on illegal", {15'h0000, busy}, 16'h0000);
    end
    $display("illegal test done");
    init_state();
    mem_wait = 4;
    issue(16'h0a93);
    repeat (2) @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= 16'h0a03;
    load_valid <= 1'b1;
    load_index <= 3'h3;
    load_data <= 16'hdead;
    @(posedge clk);
    instr_valid <= 1'b0;
    load_valid <= 1'b0;
    wait_end();
    check("busy refusal addr", result_addr, 16'h0100);
    check("busy refusal value", result_value, 16'h8000);
    peek(3'h3, 16'h0102);
    $display("refusal test done");
    init_state();
    mem_wait = 20;
    issue(16'h0a93);
    repeat (6) @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    check("busy after reset", {15'h0000, busy}, 16'h0000);
    check("mem_req after reset", {15'h0000, mem_req}, 16'h0000);
    check("done after reset", {15'h0000, done}, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    mem_wait = 0;
    init_state();
    run_instr(16'h0a83);
    check("after reset value", result_value, 16'h0101);
    $display("mid reset test done");
    summarize();
  end
endmodule : operand_address_mode_decoder_bench
`default_nettype wire
